// ### rtl/eer_pkg.sv
// Constants and types for the exception entry and return controller.
// Assumes a single core clock; used by rtl/eer_ctrl.sv and the testbench.
//
// Behaviour
// - Table base resets to zero; privileged writes relocate it up to the top.
// - Base aligned to 32 words, or table size rounded to power of two.
// - Lower priority value is more urgent and wins arbitration.
// - Reset, NMI, hard fault fixed negative; others 0-255, default 0.
// - Equal priority: smallest exception number wins.
// - Equal priority to running handler never preempts; stays pending.
// - Priority splits into group and subpriority; only group preempts.
// - Equal group: order by subpriority, then smallest number.
// - Pending qualifying exception at handler end tail-chains, no unstack.
// - Higher arrival during stacking retargets vector fetch, stacking goes on.
// - Entry only in thread mode or when outranking current handler.
// - Exception not beating the mask limit stays pending.
// - Entry pushes eight words; float in use reserves a 104-byte frame but pushes no float words.
// - Stack pointer ends at lowest frame address, 8-byte aligned.
// - Frame holds next instruction address, reloaded on return.
// - Vector fetched during stacking; handler starts after stacking.
// - Link register gets return code naming stack and prior mode.
// - Taken exception goes pending to active; late-arrival leaves earlier pending.
// - Return recognised on pop, load to counter, or branch-exchange in handler.
// - Valid return codes have bits 31 to 5 set.
// - Codes F1, F9, FD, E1, E9, ED select mode, stack and float restore.
// - Fixed priorities -3, -2, -1 with vectors at 0x4, 0x8, 0xC.

package eer_pkg;

  localparam int unsigned NUM_EXC = 32;
  localparam int unsigned EXC_W = 5;
  localparam int unsigned PRI_W = 10;

  // Internal priority: configured value biased by 4 so fixed ones sit below
  localparam logic [9:0] PRI_BIAS = 10'h004;
  localparam logic [9:0] PRI_RESET = 10'h001;
  localparam logic [9:0] PRI_NMI = 10'h002;
  localparam logic [9:0] PRI_HARD = 10'h003;
  localparam logic [9:0] PRI_IDLE = 10'h3FF;

  localparam logic [4:0] EXC_RESET = 5'h01;
  localparam logic [4:0] EXC_NMI = 5'h02;
  localparam logic [4:0] EXC_HARD = 5'h03;

  localparam logic [31:0] TBASE_RESET = 32'h0000_0000;
  localparam logic [31:0] TBASE_TOP = 32'hFFFF_FF80;
  localparam logic [31:0] FRAME_BYTES = 32'h0000_0020;
  localparam logic [31:0] FP_FRAME_BYTES = 32'h0000_0068;
  localparam logic [31:0] ALIGN8_MASK = 32'hFFFF_FFF8;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [3:0] BASIC_WORDS = 4'h8;
  // Cycles from a vector retarget until the fetched word reaches the output
  localparam logic [1:0] VEC_WAIT = 2'h3;

  localparam logic [26:0] RET_PREFIX = 27'h7FF_FFFF;
  localparam logic [31:0] RET_HND_MAIN = 32'hFFFF_FFF1;
  localparam logic [31:0] RET_THR_MAIN = 32'hFFFF_FFF9;
  localparam logic [31:0] RET_THR_PROC = 32'hFFFF_FFFD;
  localparam logic [31:0] RET_HND_MAIN_FP = 32'hFFFF_FFE1;
  localparam logic [31:0] RET_THR_MAIN_FP = 32'hFFFF_FFE9;
  localparam logic [31:0] RET_THR_PROC_FP = 32'hFFFF_FFED;

  localparam logic [2:0] REG_TBASE = 3'h0;
  localparam logic [2:0] REG_GROUP = 3'h1;
  localparam logic [2:0] REG_MASK = 3'h2;
  localparam logic [2:0] REG_PRI = 3'h3;
  localparam logic [2:0] REG_STATE = 3'h4;
  localparam logic [2:0] REG_CFG = 3'h5;

  typedef enum logic [2:0] {
    ST_RUN, ST_STACK, ST_START, ST_UNSTACK
  } eer_state_e;

endpackage

// ### rtl/eer_ctrl.sv
// Exception sequencer: arbitration, stacking, vector fetch, return decode.
// Assumes requests and pipeline strobes are synchronous to i_ref_clk and
// the memory port accepts one word per cycle with no wait.

`timescale 1ns/1ps

module eer_ctrl #(
  parameter int unsigned TABLE_ALIGN_LOG2 = 7 // Bytes; 128 = 32 words
) (
  input wire logic i_ref_clk, // Core clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic [31:0] i_irq, // Pending requests per exception number
  input wire logic i_priv, // Current access is privileged
  input wire logic i_fp_active, // Float state in use
  input wire logic i_use_psp, // Thread mode runs on process stack
  input wire logic [31:0] i_main_stack_ptr, // Main stack pointer
  input wire logic [31:0] i_process_stack_ptr, // Process stack pointer
  input wire logic [31:0] i_next_pc, // Next instruction address
  input wire logic [31:0] i_frame_word, // Other frame words from core
  input wire logic [31:0] i_vec_rdata, // Vector read data
  input wire logic i_first_exec, // Handler first insn in execute
  input wire logic i_pc_load, // Pop, load or branch-exchange to counter
  input wire logic [31:0] i_pc_value, // Value being loaded to counter
  input wire logic [2:0] i_reg_addr, // Register index
  input wire logic [31:0] i_reg_wdata, // Register write data
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  output logic [31:0] o_reg_rdata, // Read data, cycle after strobe
  output logic o_handler_mode, // Core in handler mode
  output logic o_stk_wr, // Frame word write strobe
  output logic [31:0] o_stk_addr, // Frame word address
  output logic [31:0] o_stk_wdata, // Frame word data
  output logic o_vec_rd, // Vector read strobe
  output logic [31:0] o_vec_addr, // Vector address
  output logic o_sp_load, // Load new stack pointer
  output logic o_sp_is_psp, // Stack pointer written is process one
  output logic [31:0] o_sp_value, // New stack pointer
  output logic o_start, // Start handler
  output logic [31:0] o_handler_addr, // Handler start address
  output logic [31:0] o_link_reg, // Exception return code
  output logic o_unstack, // Restore frame pulse
  output logic o_ret_fp, // Restore includes float state
  output logic o_ret_psp, // Restore from process stack
  output logic o_ret_thread // Return lands in thread mode
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [31:0] vector_base_offset_reg;
  logic [2:0] prigroup;
  logic [7:0] mask_level;
  logic mask_en;
  logic [7:0] pri_cfg [eer_pkg::NUM_EXC];
  logic [31:0] pend;
  logic [31:0] act;
  logic [eer_pkg::PRI_W-1:0] act_pri [eer_pkg::NUM_EXC];
  eer_pkg::eer_state_e state;
  logic [4:0] cur_exc;
  logic [4:0] tgt_exc;
  logic [3:0] word_cnt;
  logic [31:0] frame_base;
  logic fp_frame;
  logic psp_frame;
  logic from_thread;
  logic [31:0] vec_data;
  logic [1:0] vec_wait;

  localparam logic [31:0] ALIGN_MASK =
    ~((32'h0000_0001 << TABLE_ALIGN_LOG2) - 32'h0000_0001);

  // Group part of a configured priority; subpriority bits are cleared
  function automatic logic [7:0] group_of(input logic [7:0] p,
                                          input logic [2:0] g);
    logic [7:0] m;
    // Widened so a split of seven does not wrap the shift to zero
    m = 8'hFF << (4'(g) + 4'h1);
    return p & m;
  endfunction

  function automatic logic [eer_pkg::PRI_W-1:0] exc_pri(
      input logic [4:0] n, input logic [7:0] p, input logic grp,
      input logic [2:0] g);
    logic [7:0] v;
    v = grp ? group_of(p, g) : p;
    if (n == eer_pkg::EXC_RESET) begin
      return eer_pkg::PRI_RESET;
    end else if (n == eer_pkg::EXC_NMI) begin
      return eer_pkg::PRI_NMI;
    end else if (n == eer_pkg::EXC_HARD) begin
      return eer_pkg::PRI_HARD;
    end
    return {2'b00, v} + eer_pkg::PRI_BIAS;
  endfunction

  // ------------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------------
  logic [4:0] best_exc;
  logic [eer_pkg::PRI_W-1:0] best_pri;
  logic best_valid;
  logic [eer_pkg::PRI_W-1:0] run_pri;
  logic [eer_pkg::PRI_W-1:0] mask_pri;
  logic [eer_pkg::PRI_W-1:0] best_grp;
  logic can_take;
  logic is_return;

  always_comb begin
    logic [eer_pkg::PRI_W-1:0] full;
    best_exc = '0;
    best_pri = eer_pkg::PRI_IDLE;
    best_valid = 1'b0;
    full = '0;
    // Ascending scan with strict compare keeps the lowest number on ties
    for (int i = 1; i < eer_pkg::NUM_EXC; i++) begin
      full = exc_pri(5'(i), pri_cfg[i], 1'b0, prigroup);
      if (pend[i] && !act[i] && full < best_pri) begin
        best_pri = full;
        best_exc = 5'(i);
        best_valid = 1'b1;
      end
    end
  end

  always_comb begin
    run_pri = eer_pkg::PRI_IDLE;
    for (int i = 1; i < eer_pkg::NUM_EXC; i++) begin
      // The returning handler no longer counts, so tail chains can qualify
      if (act[i] && !(is_return && 5'(i) == cur_exc) &&
          act_pri[i] < run_pri) begin
        run_pri = act_pri[i];
      end
    end
  end

  assign best_grp = exc_pri(best_exc, pri_cfg[best_exc], 1'b1, prigroup);
  assign mask_pri = mask_en ?
    ({2'b00, group_of(mask_level, prigroup)} + eer_pkg::PRI_BIAS) :
    eer_pkg::PRI_IDLE;
  // Only the group field may preempt; equal group never does
  assign can_take = best_valid && (best_grp < mask_pri) &&
                    (best_grp < run_pri);

  assign o_handler_mode = |act;

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      vector_base_offset_reg <= eer_pkg::TBASE_RESET;
      prigroup <= '0;
      mask_level <= '0;
      mask_en <= 1'b0;
    end else if (i_reg_wr && i_priv) begin
      unique case (i_reg_addr)
        eer_pkg::REG_TBASE:
          vector_base_offset_reg <= i_reg_wdata & ALIGN_MASK &
                                    eer_pkg::TBASE_TOP;
        eer_pkg::REG_GROUP: prigroup <= i_reg_wdata[2:0];
        eer_pkg::REG_MASK: begin
          mask_level <= i_reg_wdata[7:0];
          mask_en <= i_reg_wdata[8];
        end
        default: ;
      endcase
    end
  end

  // Priority write: data[4:0] exception number, data[15:8] value
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < eer_pkg::NUM_EXC; i++) begin
        pri_cfg[i] <= '0;
      end
    end else if (i_reg_wr && i_priv && i_reg_addr == eer_pkg::REG_PRI) begin
      pri_cfg[i_reg_wdata[4:0]] <= i_reg_wdata[15:8];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        eer_pkg::REG_TBASE: o_reg_rdata <= vector_base_offset_reg;
        eer_pkg::REG_GROUP: o_reg_rdata <= {29'h0, prigroup};
        eer_pkg::REG_MASK: o_reg_rdata <= {23'h0, mask_en, mask_level};
        eer_pkg::REG_STATE: o_reg_rdata <= {act[15:0], pend[15:0]};
        eer_pkg::REG_CFG: o_reg_rdata <= {22'h0, 1'b1, 9'h0};
        default: o_reg_rdata <= '0;
      endcase
    end else begin
      o_reg_rdata <= '0;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  logic [31:0] cur_sp;
  logic [31:0] frame_size;
  logic [31:0] new_sp;
  logic late;

  assign cur_sp = (!o_handler_mode && i_use_psp) ? i_process_stack_ptr :
                  i_main_stack_ptr;
  assign frame_size = i_fp_active ? eer_pkg::FP_FRAME_BYTES :
                      eer_pkg::FRAME_BYTES;
  assign new_sp = (cur_sp - frame_size) & eer_pkg::ALIGN8_MASK;
  assign is_return = o_handler_mode && i_pc_load &&
                     i_pc_value[31:5] == eer_pkg::RET_PREFIX;
  assign late = (state == eer_pkg::ST_STACK ||
                 state == eer_pkg::ST_START) &&
                best_valid && best_grp < exc_pri(tgt_exc,
                  pri_cfg[tgt_exc], 1'b1, prigroup) &&
                best_grp < mask_pri;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state <= eer_pkg::ST_RUN;
      tgt_exc <= '0;
      cur_exc <= '0;
      word_cnt <= '0;
      frame_base <= '0;
      fp_frame <= 1'b0;
      psp_frame <= 1'b0;
      from_thread <= 1'b0;
      vec_wait <= '0;
    end else begin
      unique case (state)
        eer_pkg::ST_RUN: begin
          if (is_return && can_take) begin
            tgt_exc <= best_exc;
            vec_wait <= eer_pkg::VEC_WAIT;
            state <= eer_pkg::ST_START;
          end else if (is_return) begin
            state <= eer_pkg::ST_UNSTACK;
          end else if (can_take) begin
            tgt_exc <= best_exc;
            vec_wait <= '0;
            word_cnt <= '0;
            frame_base <= new_sp;
            fp_frame <= i_fp_active;
            psp_frame <= !o_handler_mode && i_use_psp;
            from_thread <= !o_handler_mode;
            state <= eer_pkg::ST_STACK;
          end
        end
        eer_pkg::ST_STACK: begin
          if (late) begin
            tgt_exc <= best_exc;
            vec_wait <= eer_pkg::VEC_WAIT;
          end
          word_cnt <= word_cnt + 4'h1;
          if (word_cnt == eer_pkg::BASIC_WORDS - 4'h1) begin
            state <= eer_pkg::ST_START;
          end
        end
        eer_pkg::ST_START: begin
          if (late && !i_first_exec) begin
            tgt_exc <= best_exc;
            vec_wait <= eer_pkg::VEC_WAIT;
          end else if (i_first_exec) begin
            cur_exc <= tgt_exc;
            state <= eer_pkg::ST_RUN;
          end else if (vec_wait != 2'h0) begin
            vec_wait <= vec_wait - 2'h1;
          end
        end
        eer_pkg::ST_UNSTACK: state <= eer_pkg::ST_RUN;
        default: state <= eer_pkg::ST_RUN;
      endcase
    end
  end

  // Pending and active; a new request wins over the clear on entry
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pend <= '0;
      act <= '0;
      for (int i = 0; i < eer_pkg::NUM_EXC; i++) begin
        act_pri[i] <= eer_pkg::PRI_IDLE;
      end
    end else begin
      if (state == eer_pkg::ST_START && i_first_exec) begin
        pend[tgt_exc] <= 1'b0;
        act[tgt_exc] <= 1'b1;
        act_pri[tgt_exc] <= exc_pri(tgt_exc, pri_cfg[tgt_exc], 1'b1,
                                    prigroup);
      end
      if (is_return && state == eer_pkg::ST_RUN) begin
        act[cur_exc] <= 1'b0;
        act_pri[cur_exc] <= eer_pkg::PRI_IDLE;
      end
      for (int i = 1; i < eer_pkg::NUM_EXC; i++) begin
        if (i_irq[i]) begin
          pend[i] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Memory side outputs
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_stk_wr <= 1'b0;
      o_stk_addr <= '0;
      o_stk_wdata <= '0;
      o_vec_rd <= 1'b0;
      o_vec_addr <= '0;
      vec_data <= '0;
    end else begin
      o_stk_wr <= state == eer_pkg::ST_STACK;
      o_stk_addr <= frame_base + {26'h0, word_cnt, 2'b00};
      // Word six of the frame is the resume address
      o_stk_wdata <= (word_cnt == 4'h6) ? i_next_pc :
                     i_frame_word;
      // Fetch repeats each cycle so a late retarget reads the new slot
      // Start phase fetches too, for tail chains and late retargets
      o_vec_rd <= state == eer_pkg::ST_STACK ||
                  state == eer_pkg::ST_START;
      o_vec_addr <= vector_base_offset_reg +
                    ({27'h0, tgt_exc} * eer_pkg::WORD_BYTES);
      if (o_vec_rd) begin
        vec_data <= i_vec_rdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_sp_load <= 1'b0;
      o_sp_is_psp <= 1'b0;
      o_sp_value <= '0;
      o_start <= 1'b0;
      o_handler_addr <= '0;
      o_link_reg <= eer_pkg::RET_THR_MAIN;
      o_unstack <= 1'b0;
      o_ret_fp <= 1'b0;
      o_ret_psp <= 1'b0;
      o_ret_thread <= 1'b0;
    end else begin
      o_sp_load <= state == eer_pkg::ST_STACK &&
                   word_cnt == eer_pkg::BASIC_WORDS - 4'h1;
      o_sp_is_psp <= psp_frame;
      o_sp_value <= frame_base;
      o_start <= state == eer_pkg::ST_START && !late &&
                 vec_wait == 2'h0;
      o_handler_addr <= vec_data;
      if (state == eer_pkg::ST_START) begin
        o_link_reg <= !from_thread ?
          (fp_frame ? eer_pkg::RET_HND_MAIN_FP : eer_pkg::RET_HND_MAIN) :
          psp_frame ?
          (fp_frame ? eer_pkg::RET_THR_PROC_FP : eer_pkg::RET_THR_PROC) :
          (fp_frame ? eer_pkg::RET_THR_MAIN_FP :
                      eer_pkg::RET_THR_MAIN);
      end
      o_unstack <= is_return && !can_take && state == eer_pkg::ST_RUN;
      o_ret_fp <= !i_pc_value[4];
      o_ret_psp <= i_pc_value[2];
      o_ret_thread <= i_pc_value[3];
    end
  end

endmodule

// ### bench/eer_monitor.sv
// Port checker for the exception sequencer.
// Bound to eer_ctrl below; watches only its top-level ports.
`timescale 1ns/1ps

module eer_monitor (
  input wire logic i_ref_clk, // Core clock
  input wire logic i_rst_n, // Sync reset, active low
  input wire logic i_pc_load, // Counter load pulse
  input wire logic [31:0] i_pc_value, // Value loaded
  input wire logic i_reg_rd, // Read strobe
  input wire logic [2:0] i_reg_addr, // Register index
  input wire logic [31:0] o_reg_rdata, // Read data
  input wire logic o_handler_mode, // Handler mode
  input wire logic o_stk_wr, // Frame word write
  input wire logic o_vec_rd, // Vector read
  input wire logic o_sp_load, // Stack pointer load
  input wire logic [31:0] o_sp_value, // New stack pointer
  input wire logic o_start, // Handler start
  input wire logic [31:0] o_link_reg, // Return code
  input wire logic o_unstack, // Restore pulse
  input wire logic o_ret_fp, // Float restore
  input wire logic o_ret_psp, // Process stack restore
  input wire logic o_ret_thread // Thread mode return
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // ------------------------------------------------------------
  // Sequences and properties
  // ------------------------------------------------------------
  sequence s_burst;
    o_stk_wr [*8] ##1 !o_stk_wr;
  endsequence
  sequence s_ret_req;
    i_pc_load && i_pc_value[31:5] == 27'h7FF_FFFF && o_handler_mode;
  endsequence

  property p_link_rst;
    $rose(i_rst_n) |-> o_link_reg == 32'hFFFF_FFF9 && !o_handler_mode;
  endproperty
  property p_burst;
    $rose(o_stk_wr) |-> s_burst;
  endproperty
  property p_vec_par;
    o_stk_wr |-> o_vec_rd;
  endproperty
  property p_sp_after;
    $fell(o_stk_wr) |-> $past(o_sp_load) && $past(o_sp_value[2:0]) == 3'h0;
  endproperty
  property p_start_gap;
    o_start |-> !o_stk_wr;
  endproperty
  property p_code;
    o_link_reg[31:5] == 27'h7FF_FFFF;
  endproperty
  property p_unstack_cause;
    $rose(o_unstack) |-> $past(i_pc_load) && $past(o_handler_mode)
      && $past(i_pc_value[31:5]) == 27'h7FF_FFFF;
  endproperty
  property p_ret_dec;
    $rose(o_unstack) |-> o_ret_thread == $past(i_pc_value[3])
      && o_ret_psp == $past(i_pc_value[2])
      && o_ret_fp == !$past(i_pc_value[4]);
  endproperty
  property p_base_align;
    $past(i_reg_rd) && $past(i_reg_addr) == 3'h0 |-> o_reg_rdata[6:0] == 7'h00;
  endproperty
  property p_tail;
    s_ret_req ##1 !o_unstack |-> !o_stk_wr [*8];
  endproperty

  a_link_rst: assert property (p_link_rst)
    else $error("link register wrong after reset");
  a_burst: assert property (p_burst)
    else $error("frame burst not eight words");
  a_vec_par: assert property (p_vec_par)
    else $error("vector fetch not alongside stacking");
  a_sp_after: assert property (p_sp_after)
    else $error("stack pointer load missing or unaligned");
  a_start_gap: assert property (p_start_gap)
    else $error("handler started while stacking");
  a_code: assert property (p_code)
    else $error("return code upper bits not all ones");
  a_unstack_cause: assert property (p_unstack_cause)
    else $error("restore without a return load");
  a_ret_dec: assert property (p_ret_dec)
    else $error("return decode wrong");
  a_base_align: assert property (p_base_align)
    else $error("table base low bits not dropped");
  a_tail: assert property (p_tail)
    else $error("tail chain stacked a frame");
endmodule

bind eer_ctrl eer_monitor eer_monitor_inst (.i_ref_clk, .i_rst_n,
  .i_pc_load, .i_pc_value, .i_reg_rd, .i_reg_addr, .o_reg_rdata,
  .o_handler_mode, .o_stk_wr, .o_vec_rd, .o_sp_load, .o_sp_value,
  .o_start, .o_link_reg, .o_unstack, .o_ret_fp, .o_ret_psp,
  .o_ret_thread);

// ### bench/eer_core_model.sv
// Core pipeline and vector memory seen from the sequencer.
// Answers vector reads one cycle later; delay sets first execute.
`timescale 1ns/1ps

module eer_core_model (
  input wire logic i_ref_clk, // Core clock
  input wire logic i_vec_rd, // Vector read strobe
  input wire logic [31:0] i_vec_addr, // Vector address
  input wire logic i_start, // Handler start
  input wire logic [3:0] i_delay, // Cycles before first execute
  output logic [31:0] o_vec_rdata, // Vector word
  output logic o_first_exec // First handler insn in execute
);
  logic prev_start = 1'b0;
  logic busy = 1'b0;
  logic [3:0] cnt = 4'h0;

  initial o_vec_rdata = 32'h0000_0000;
  initial o_first_exec = 1'b0;

  always @(posedge i_ref_clk) begin
    // Idle cycles flip the word so stale data is never trusted
    if (i_vec_rd)
      o_vec_rdata <= 32'h0800_0000 | i_vec_addr | 32'h0000_0001;
    else
      o_vec_rdata <= ~o_vec_rdata;
    prev_start <= i_start;
    o_first_exec <= 1'b0;
    if (i_start && !prev_start && !busy) begin
      busy <= 1'b1;
      cnt <= i_delay;
    end else if (busy) begin
      if (cnt == 4'h0) begin
        o_first_exec <= 1'b1;
        busy <= 1'b0;
      end else
        cnt <= cnt - 4'h1;
    end
  end
endmodule

// ### bench/tb.sv
// Self-checking bench for the exception sequencer.
// Drives requests, registers and returns; core model answers vectors.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; \
  if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [31:0] i_irq = 32'h0000_0000;
  logic i_priv = 1'b0, i_fp_active = 1'b0, i_use_psp = 1'b0;
  logic [31:0] i_main_stack_ptr, i_process_stack_ptr, i_next_pc;
  logic [31:0] i_frame_word = 32'h0000_0000, i_vec_rdata;
  logic i_first_exec, i_pc_load = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [31:0] i_pc_value = 32'h0000_0000, i_reg_wdata = 32'h0000_0000;
  logic [2:0] i_reg_addr = 3'h0;
  logic [31:0] o_reg_rdata, o_stk_addr, o_stk_wdata, o_vec_addr;
  logic [31:0] o_sp_value, o_handler_addr, o_link_reg;
  logic o_handler_mode, o_stk_wr, o_vec_rd, o_sp_load, o_sp_is_psp;
  logic o_start, o_unstack, o_ret_fp, o_ret_psp, o_ret_thread;
  int n_mismatch = 0, checks_done = 0, seed = 61, n_unstack = 0;
  logic [31:0] base, rd_val, sp_seen, stk_q[$];
  logic [3:0] dly = 4'h0;

  always #10 i_ref_clk = ~i_ref_clk;

  eer_ctrl eer_ctrl_inst (.i_ref_clk, .i_rst_n, .i_irq, .i_priv,
    .i_fp_active, .i_use_psp, .i_main_stack_ptr, .i_process_stack_ptr,
    .i_next_pc, .i_frame_word, .i_vec_rdata, .i_first_exec, .i_pc_load,
    .i_pc_value, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .o_handler_mode, .o_stk_wr, .o_stk_addr, .o_stk_wdata,
    .o_vec_rd, .o_vec_addr, .o_sp_load, .o_sp_is_psp, .o_sp_value,
    .o_start, .o_handler_addr, .o_link_reg, .o_unstack, .o_ret_fp,
    .o_ret_psp, .o_ret_thread);
  eer_core_model eer_core_model_inst (.i_ref_clk, .i_vec_rd(o_vec_rd),
    .i_vec_addr(o_vec_addr), .i_start(o_start), .i_delay(dly),
    .o_vec_rdata(i_vec_rdata), .o_first_exec(i_first_exec));

  // ------------------------------------------------------------
  // Capture and bus tasks
  // ------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    i_frame_word <= $random(seed);
    if (o_stk_wr === 1'b1) stk_q.push_back(o_stk_wdata);
    if (o_sp_load === 1'b1) sp_seen = o_sp_value;
    if (o_unstack === 1'b1) n_unstack++;
  end

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [31:0] d,
                    input logic p);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_priv <= p;
    i_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  task automatic irq(input logic [31:0] m);
    stk_q.delete();
    @(posedge i_ref_clk);
    i_irq <= m;
    @(posedge i_ref_clk);
    i_irq <= 32'h0000_0000;
  endtask

  // Stacked entry when sp is nonzero, tail chain otherwise
  task automatic entry(input int exc, input logic [31:0] link,
                       input logic [31:0] sp);
    int k;
    for (k = 0; k < 80 && o_start !== 1'b1; k++) begin
      @(posedge i_ref_clk);
      #1;
    end
    if (k == 80) begin
      n_mismatch++;
      close_out();
    end
    `CHK("handler", 32'h0800_0001 | (base + 32'(exc) * 4), o_handler_addr)
    if (sp != 0) begin
      `CHK("frame words", 8, stk_q.size())
      `CHK("resume", 1'b1, i_next_pc inside {stk_q})
      `CHK("sp", sp, sp_seen)
    end else
      `CHK("tail stack", 0, stk_q.size())
    repeat (dly + 6) @(posedge i_ref_clk);
    #1;
    `CHK("mode", 1'b1, o_handler_mode)
    `CHK("link", link, o_link_reg)
  endtask

  task automatic ret(input logic [31:0] code, input int exp);
    n_unstack = 0;
    @(posedge i_ref_clk);
    i_pc_value <= code;
    i_pc_load <= 1'b1;
    @(posedge i_ref_clk);
    i_pc_load <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    `CHK("unstack", exp, n_unstack)
    if (exp == 1) begin
      `CHK("ret thread", code[3], o_ret_thread)
      `CHK("ret psp", code[2], o_ret_psp)
      `CHK("ret fp", !code[4], o_ret_fp)
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    i_main_stack_ptr = $random(seed) & 32'hFFFF_FFFC;
    i_process_stack_ptr = $random(seed) & 32'hFFFF_FFFC;
    i_next_pc = $random(seed) & 32'hFFFF_FFFE;
    base = 32'h0000_0000;
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    `CHK("link reset", 32'hFFFF_FFF9, o_link_reg)
    rd(eer_pkg::REG_TBASE, rd_val);
    `CHK("base reset", 0, rd_val)
    rd(eer_pkg::REG_CFG, rd_val);
    `CHK("align bit", 1'b1, rd_val[9])
    rd(3'h7, rd_val);
    `CHK("unmapped", 0, rd_val)
    wr(eer_pkg::REG_TBASE, $random(seed), 1'b0);
    rd(eer_pkg::REG_TBASE, rd_val);
    `CHK("unprivileged", 0, rd_val)
    base = $random(seed);
    wr(eer_pkg::REG_TBASE, base, 1'b1);
    base = base & 32'hFFFF_FF80;
    rd(eer_pkg::REG_TBASE, rd_val);
    `CHK("base", base, rd_val)
    // Equal default priority: lower number first, other stays pending
    irq(32'h0000_0240);
    entry(6, 32'hFFFF_FFF9, (i_main_stack_ptr - 32) & 32'hFFFF_FFF8);
    rd(eer_pkg::REG_STATE, rd_val);
    `CHK("state", 32'h0040_0200, rd_val)
    stk_q.delete();
    ret(32'hFFFF_FFF9, 0);
    entry(9, 32'hFFFF_FFF9, 0);
    ret(32'hFFFF_FFF9, 1);
    // Mask blocks everything configurable, then lifts; slow core
    wr(eer_pkg::REG_MASK, 32'h0000_0100, 1'b1);
    irq(32'h0000_0020);
    repeat (30) @(posedge i_ref_clk);
    `CHK("masked", 0, stk_q.size())
    i_use_psp <= 1'b1;
    dly <= 4'h5;
    wr(eer_pkg::REG_MASK, 32'h0000_0000, 1'b1);
    entry(5, 32'hFFFF_FFFD, (i_process_stack_ptr - 32) & 32'hFFFF_FFF8);
    // Equal priority waits; fixed priority preempts with float frame
    irq(32'h0000_0100);
    repeat (30) @(posedge i_ref_clk);
    `CHK("no preempt", 0, stk_q.size())
    i_fp_active <= 1'b1;
    irq(32'h0000_0004);
    entry(2, 32'hFFFF_FFE1, (i_main_stack_ptr - 104) & 32'hFFFF_FFF8);
    ret(32'hFFFF_FFE1, 1);
    close_out();
  end
endmodule
